// >>> shared/gsi_pkg.sv
// package: shared constants and types for the gripper state indicator
package gsi_pkg;

  // clock rate and timing figures
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BOOT_FAIL_MS = 5000;
  localparam int unsigned BOOT_FAIL_CYC = BOOT_FAIL_MS * (CLK_HZ / 1000);
  localparam int unsigned SLOW_PULSE_MS = 2000;
  localparam int unsigned SLOW_PULSE_CYC = SLOW_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_PULSE_MS = 500;
  localparam int unsigned FAST_PULSE_CYC = FAST_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned ONCE_MS = 300;
  localparam int unsigned ONCE_CYC = ONCE_MS * (CLK_HZ / 1000);
  localparam int unsigned CODE_MS = 200;
  localparam int unsigned CODE_CYC = CODE_MS * (CLK_HZ / 1000);
  localparam int unsigned ACT_MS = 50;
  localparam int unsigned ACT_CYC = ACT_MS * (CLK_HZ / 1000);
  localparam int unsigned RESTART_MS = 1000;
  localparam int unsigned RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);

  // host command codes
  localparam logic [7:0] CMD_GRIP = 8'h25;
  localparam logic [7:0] CMD_RELEASE = 8'h26;
  localparam logic [7:0] CMD_PREPOS = 8'h21;
  localparam logic [7:0] CMD_STOP = 8'h22;
  localparam logic [7:0] CMD_ACK = 8'h24;
  localparam logic [7:0] CMD_STATE_QUERY = 8'h40;

  // status word field positions
  localparam int unsigned SW_FAST_HALT_BIT = 0;
  localparam int unsigned SW_WARN_BIT = 1;
  localparam int unsigned SW_SCRIPT_BIT = 2;
  localparam int unsigned SW_FAULT_BIT = 3;
  localparam int unsigned SW_BUSY_BIT = 4;
  localparam logic [15:0] SW_RESET = 16'h0000;

  // colour code on the rgb indicator {r,g,b}
  localparam logic [2:0] COL_OFF = 3'h0;
  localparam logic [2:0] COL_BLUE = 3'h1;
  localparam logic [2:0] COL_GREEN = 3'h2;
  localparam logic [2:0] COL_RED = 3'h4;
  localparam logic [2:0] COL_VIOLET = 3'h5;
  localparam logic [2:0] COL_YELLOW = 3'h6;
  localparam logic [2:0] COL_WHITE = 3'h7;

  typedef enum logic [2:0] {
    GS_IDLE = 3'b000,
    GS_GRIPPING = 3'b001,
    GS_HOLDING = 3'b010,
    GS_PART_LOST = 3'b011,
    GS_NO_PART = 3'b100,
    GS_RELEASING = 3'b101,
    GS_POSITIONING = 3'b110,
    GS_ERROR = 3'b111
  } gsi_grip_t;

  typedef enum logic [2:0] {
    PH_LOAD = 3'b000,
    PH_TERMINAL = 3'b001,
    PH_LOAD_FAIL = 3'b010,
    PH_STARTING = 3'b011,
    PH_RUN = 3'b100,
    PH_SW_FAULT = 3'b101
  } gsi_phase_t;

  typedef enum logic [2:0] {
    PAT_OFF = 3'b000,
    PAT_STEADY = 3'b001,
    PAT_FLASH = 3'b010,
    PAT_SLOW = 3'b011,
    PAT_FAST = 3'b100,
    PAT_CODE = 3'b101
  } gsi_pat_t;

endpackage : gsi_pkg

// >>> src/gsi_activity.sv
// module: activity led, lit while active, blinks off on traffic
`timescale 1ns/1ns
module gsi_activity
  import gsi_pkg::*;
#(
  parameter int unsigned BLINK_CYC = ACT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic active_pin,
  input wire logic traffic_pin,
  output logic led
);

  typedef struct packed {
    logic [1:0] act_sync;
    logic [1:0] trf_sync;
    logic trf_last;
    logic [31:0] blink;
    logic led;
  } gsi_act_state_t;

  gsi_act_state_t s_q;
  gsi_act_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.act_sync = {s_q.act_sync[0], active_pin};
    s_d.trf_sync = {s_q.trf_sync[0], traffic_pin};
    s_d.trf_last = s_q.trf_sync[1];
    if (s_q.trf_sync[1] && !s_q.trf_last)
      s_d.blink = 32'(BLINK_CYC);
    else if (s_q.blink != 32'h0)
      s_d.blink = s_q.blink - 32'h1;
    s_d.led = s_q.act_sync[1] && ((s_q.blink == 32'h0) || s_q.blink[0]);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end

  assign led = s_q.led;

endmodule : gsi_activity

// >>> src/gsi_core.sv
// module: gripper state machine, boot phases and operating-state indicator
//
// Behaviour
// - blue steady while firmware loads
// - violet steady while a terminal drives the boot loader
// - load failure: red about five seconds, then restart loader, blue again
// - blue flashing while operating software starts
// - white slow pulse while waiting for a command
// - white fast pulse while initialising or executing
// - green fast pulse while a script runs
// - yellow fast pulse when a warning limit is reached
// - one green pulse on an error-free command
// - one red pulse on a command error
// - critical fault: fast red pulse, motion refused until acknowledged
// - software fault: red code two short, long pause, restart later
// - card and network leds lit while active, flash with traffic
// - query command 40h returns the status word
// - idle reported when no grip process runs
// - gripping state moves fingers and enables part detection
// - holding state with grip monitoring enabled
// - force lost while holding gives part-lost
// - closing to position without part gives no-part-found
// - releasing while opening, positioning during pre-position
// - failed command: error state, fast halt flag, resume after ack
// - stop outside error aborts and returns to idle at once
// - boot loader retries until firmware loads
`timescale 1ns/1ns
module gsi_core
  import gsi_pkg::*;
#(
  parameter int unsigned FAIL_CYC = BOOT_FAIL_CYC,
  parameter int unsigned RST_CYC = RESTART_CYC,
  parameter int unsigned PULSE_ONCE_CYC = ONCE_CYC,
  parameter int unsigned SLOW_CYC = SLOW_PULSE_CYC,
  parameter int unsigned FAST_CYC = FAST_PULSE_CYC,
  parameter int unsigned FL_CYC = FLASH_CYC,
  parameter int unsigned CD_CYC = CODE_CYC,
  parameter int unsigned BLINK_CYC = ACT_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // host command port, same clock
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic cmd_done,
  output logic cmd_ok,
  output logic [15:0] status_word,
  output logic [2:0] grip_state,
  // boot and system events, same clock
  input wire logic boot_done,
  input wire logic boot_fail,
  input wire logic terminal_present,
  input wire logic start_done,
  input wire logic sw_fault,
  input wire logic crit_fault,
  input wire logic warn_limit,
  input wire logic script_run,
  input wire logic init_busy,
  // motion feedback, same clock
  input wire logic part_contact,
  input wire logic force_lost,
  input wire logic pos_reached,
  input wire logic move_fail,
  output logic fingers_close,
  output logic fingers_open,
  output logic part_detect_en,
  output logic grip_monitor_en,
  output logic boot_restart,
  output logic sys_restart,
  // indicator and activity leds
  output logic [2:0] led_rgb,
  input wire logic card_active,
  input wire logic card_traffic,
  input wire logic net_active,
  input wire logic net_traffic,
  output logic card_led,
  output logic net_led
);

  typedef struct packed {
    gsi_phase_t phase;
    gsi_grip_t grip;
    logic [31:0] timer;
    logic [31:0] once_cnt;
    logic once_red;
    logic fast_halt;
    logic fault_latched;
    logic cmd_done;
    logic cmd_ok;
    logic [15:0] status;
    logic [2:0] color;
    gsi_pat_t pat;
    logic boot_restart;
    logic sys_restart;
  } gsi_core_state_t;

  gsi_core_state_t s_q;
  gsi_core_state_t s_d;
  logic pat_lit;

  function automatic logic is_motion(input logic [7:0] c);
    is_motion = (c == CMD_GRIP) || (c == CMD_RELEASE) || (c == CMD_PREPOS);
  endfunction : is_motion

  //////////////////////////////////////////////////////////////////////////////
  // boot phases, gripper state machine, command handling

  always_comb
  begin
    s_d = s_q;
    s_d.cmd_done = 1'b0;
    s_d.boot_restart = 1'b0;
    s_d.sys_restart = 1'b0;
    if (s_q.once_cnt != 32'h0)
      s_d.once_cnt = s_q.once_cnt - 32'h1;

    case (s_q.phase)
      PH_LOAD:
      begin
        if (boot_fail)
        begin
          s_d.phase = PH_LOAD_FAIL;
          s_d.timer = 32'h0;
        end
        else if (terminal_present)
          s_d.phase = PH_TERMINAL;
        else if (boot_done)
          s_d.phase = PH_STARTING;
      end
      PH_TERMINAL:
      begin
        if (!terminal_present)
          s_d.phase = PH_LOAD;
      end
      PH_LOAD_FAIL:
      begin
        if (s_q.timer + 32'h1 >= 32'(FAIL_CYC))
        begin
          s_d.phase = PH_LOAD;
          s_d.boot_restart = 1'b1;
        end
        else
          s_d.timer = s_q.timer + 32'h1;
      end
      PH_STARTING:
      begin
        if (start_done)
          s_d.phase = PH_RUN;
      end
      PH_RUN:
      begin
        if (sw_fault)
        begin
          s_d.phase = PH_SW_FAULT;
          s_d.timer = 32'h0;
        end
      end
      PH_SW_FAULT:
      begin
        if (s_q.timer + 32'h1 >= 32'(RST_CYC))
        begin
          s_d.phase = PH_LOAD;
          s_d.sys_restart = 1'b1;
          s_d.grip = GS_IDLE;
          s_d.fast_halt = 1'b0;
          s_d.fault_latched = 1'b0;
        end
        else
          s_d.timer = s_q.timer + 32'h1;
      end
      default: s_d.phase = PH_LOAD;
    endcase

    if (s_q.phase == PH_RUN)
    begin
      // motion feedback
      case (s_q.grip)
        GS_GRIPPING:
        begin
          if (move_fail)
            s_d.grip = GS_ERROR;
          else if (part_contact)
            s_d.grip = GS_HOLDING;
          else if (pos_reached)
            s_d.grip = GS_NO_PART;
        end
        GS_HOLDING:
        begin
          if (force_lost)
            s_d.grip = GS_PART_LOST;
        end
        GS_RELEASING, GS_POSITIONING:
        begin
          if (move_fail)
            s_d.grip = GS_ERROR;
          else if (pos_reached)
            s_d.grip = GS_IDLE;
        end
        default: s_d.grip = s_q.grip;
      endcase

      if (cmd_valid)
      begin
        s_d.cmd_done = 1'b1;
        s_d.cmd_ok = 1'b1;
        if (cmd_code == CMD_STATE_QUERY)
          s_d.cmd_ok = 1'b1;
        else if (cmd_code == CMD_ACK)
        begin
          // ack clears halt and leaves error
          if (!crit_fault)
          begin
            s_d.fast_halt = 1'b0;
            s_d.fault_latched = 1'b0;
            if (s_q.grip == GS_ERROR)
              s_d.grip = GS_IDLE;
          end
        end
        else if (cmd_code == CMD_STOP)
        begin
          // abort to idle except from error
          if (s_q.grip != GS_ERROR)
            s_d.grip = GS_IDLE;
        end
        else if (is_motion(cmd_code))
        begin
          if (s_q.fast_halt || s_q.grip == GS_ERROR)
            s_d.cmd_ok = 1'b0;
          else if (cmd_code == CMD_GRIP)
            s_d.grip = GS_GRIPPING;
          else if (cmd_code == CMD_RELEASE)
            s_d.grip = GS_RELEASING;
          else
            s_d.grip = GS_POSITIONING;
        end
        else
          s_d.cmd_ok = 1'b0;
        // one pulse per command, red on error
        s_d.once_cnt = 32'(PULSE_ONCE_CYC);
        s_d.once_red = ~s_d.cmd_ok;
      end
      // critical fault latches halt; set wins over ack
      if (crit_fault)
      begin
        s_d.fault_latched = 1'b1;
        s_d.fast_halt = 1'b1;
        s_d.grip = GS_ERROR;
      end
      if (move_fail && (s_q.grip != GS_IDLE) && (s_q.grip != GS_ERROR))
        s_d.fast_halt = 1'b1;
    end
    else if (cmd_valid)
    begin
      s_d.cmd_done = 1'b1;
      s_d.cmd_ok = 1'b0;
    end

    s_d.status = SW_RESET;
    s_d.status[SW_FAST_HALT_BIT] = s_d.fast_halt;
    s_d.status[SW_WARN_BIT] = warn_limit;
    s_d.status[SW_SCRIPT_BIT] = script_run;
    s_d.status[SW_FAULT_BIT] = s_d.fault_latched;
    s_d.status[SW_BUSY_BIT] = init_busy;

    case (s_q.phase)
      PH_LOAD:
      begin
        s_d.color = COL_BLUE;
        s_d.pat = PAT_STEADY;
      end
      PH_TERMINAL:
      begin
        s_d.color = COL_VIOLET;
        s_d.pat = PAT_STEADY;
      end
      PH_LOAD_FAIL:
      begin
        s_d.color = COL_RED;
        s_d.pat = PAT_STEADY;
      end
      PH_STARTING:
      begin
        s_d.color = COL_BLUE;
        s_d.pat = PAT_FLASH;
      end
      PH_SW_FAULT:
      begin
        s_d.color = COL_RED;
        s_d.pat = PAT_CODE;
      end
      default:
      begin
        if (s_q.fault_latched)
        begin
          s_d.color = COL_RED;
          s_d.pat = PAT_FAST;
        end
        else if (s_q.once_cnt != 32'h0)
        begin
          s_d.color = s_q.once_red ? COL_RED : COL_GREEN;
          s_d.pat = PAT_STEADY;
        end
        else if (warn_limit)
        begin
          s_d.color = COL_YELLOW;
          s_d.pat = PAT_FAST;
        end
        else if (script_run)
        begin
          s_d.color = COL_GREEN;
          s_d.pat = PAT_FAST;
        end
        else if (init_busy || (s_q.grip != GS_IDLE && s_q.grip != GS_HOLDING
                 && s_q.grip != GS_ERROR && s_q.grip != GS_PART_LOST
                 && s_q.grip != GS_NO_PART))
        begin
          s_d.color = COL_WHITE;
          s_d.pat = PAT_FAST;
        end
        else
        begin
          s_d.color = COL_WHITE;
          s_d.pat = PAT_SLOW;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.phase <= PH_LOAD;
      s_q.grip <= GS_IDLE;
      s_q.pat <= PAT_STEADY;
      s_q.color <= COL_BLUE;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pattern and activity leds

  gsi_pattern #(
    .SLOW_CYC(SLOW_CYC),
    .FAST_CYC(FAST_CYC),
    .FL_CYC(FL_CYC),
    .CD_CYC(CD_CYC)
  ) u_pattern (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .pattern(s_q.pat),
    .lit(pat_lit)
  );

  gsi_activity #(.BLINK_CYC(BLINK_CYC)) u_card (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .active_pin(card_active),
    .traffic_pin(card_traffic),
    .led(card_led)
  );

  gsi_activity #(.BLINK_CYC(BLINK_CYC)) u_net (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .active_pin(net_active),
    .traffic_pin(net_traffic),
    .led(net_led)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // colour gated by pattern; pattern lags colour by one cycle, invisible to the eye
  assign led_rgb = pat_lit ? s_q.color : COL_OFF;
  assign cmd_done = s_q.cmd_done;
  assign cmd_ok = s_q.cmd_ok;
  assign status_word = s_q.status;
  assign grip_state = s_q.grip;
  assign fingers_close = (s_q.grip == GS_GRIPPING) || (s_q.grip == GS_HOLDING);
  assign part_detect_en = (s_q.grip == GS_GRIPPING);
  assign grip_monitor_en = (s_q.grip == GS_HOLDING);
  assign fingers_open = (s_q.grip == GS_RELEASING) || (s_q.grip == GS_POSITIONING);
  assign boot_restart = s_q.boot_restart;
  assign sys_restart = s_q.sys_restart;

endmodule : gsi_core

// >>> src/gsi_pattern.sv
// module: indicator pattern generator (steady, flash, pulse, flash code)
`timescale 1ns/1ns
module gsi_pattern
  import gsi_pkg::*;
#(
  parameter int unsigned SLOW_CYC = SLOW_PULSE_CYC,
  parameter int unsigned FAST_CYC = FAST_PULSE_CYC,
  parameter int unsigned FL_CYC = FLASH_CYC,
  parameter int unsigned CD_CYC = CODE_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire gsi_pat_t pattern,
  output logic lit
);

  typedef struct packed {
    logic [31:0] cnt;
    logic phase;
    logic [2:0] slot;
    logic lit;
  } gsi_pat_state_t;

  gsi_pat_state_t s_q;
  gsi_pat_state_t s_d;

  function automatic logic [31:0] half_of(input gsi_pat_t p);
    case (p)
      PAT_SLOW: half_of = 32'(SLOW_CYC / 2);
      PAT_FAST: half_of = 32'(FAST_CYC / 2);
      PAT_FLASH: half_of = 32'(FL_CYC);
      PAT_CODE: half_of = 32'(CD_CYC);
      default: half_of = 32'h1;
    endcase
  endfunction : half_of

  always_comb
  begin
    s_d = s_q;
    if (s_q.cnt + 32'h1 >= half_of(pattern))
    begin
      s_d.cnt = 32'h0;
      s_d.phase = ~s_q.phase;
      // code frame of eight slots: on,off,on, then five off for the long pause
      s_d.slot = s_q.slot + 3'h1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
    case (pattern)
      PAT_STEADY: s_d.lit = 1'b1;
      PAT_FLASH, PAT_SLOW, PAT_FAST: s_d.lit = s_q.phase;
      PAT_CODE: s_d.lit = (s_q.slot == 3'h0) || (s_q.slot == 3'h2);
      default: s_d.lit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end

  assign lit = s_q.lit;

endmodule : gsi_pattern

// >>> tb/gsi_core_monitor.sv
// checker: timing properties on the gripper state indicator core ports
`timescale 1ns/1ns
module gsi_core_monitor
  import gsi_pkg::*;
#(
  parameter int unsigned FAIL_CYC = BOOT_FAIL_CYC
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_done,
  input wire logic cmd_ok,
  input wire logic [15:0] status_word,
  input wire logic [2:0] grip_state,
  input wire logic crit_fault,
  input wire logic part_contact,
  input wire logic force_lost,
  input wire logic pos_reached,
  input wire logic move_fail,
  input wire logic fingers_close,
  input wire logic fingers_open,
  input wire logic part_detect_en,
  input wire logic grip_monitor_en,
  input wire logic boot_restart,
  input wire logic [2:0] led_rgb,
  input wire logic card_active,
  input wire logic card_traffic,
  input wire logic card_led
);
  ////////////////////////////////////////////////////////////////////////////////
  // run length of red, so the load-failure display can be timed
  int unsigned red_cnt_d;
  int unsigned red_cnt_q;
  always_comb
  begin
    red_cnt_d = (led_rgb == COL_RED) ? red_cnt_q + 1 : 0;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
      red_cnt_q <= 0;
    else
      red_cnt_q <= red_cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  wire logic taken = cmd_valid && clk_en;
  sequence held_loss;
    grip_state == GS_HOLDING && force_lost && taken == 1'b0 && clk_en && !crit_fault;
  endsequence
  // synchroniser plus blink time fit inside eight quiet cycles
  sequence card_quiet;
    (card_active && !card_traffic && clk_en)[*8];
  endsequence
  cmd_answer_a: assert property (taken |=> cmd_done)
    else $error("command not answered after one cycle");
  halt_refuse_a: assert property (taken && status_word[0] && cmd_code == CMD_GRIP |=> !cmd_ok)
    else $error("motion accepted while halted");
  grip_drive_a: assert property (grip_state == GS_GRIPPING |-> fingers_close && part_detect_en)
    else $error("gripping without close or detection");
  hold_mon_a: assert property (grip_state == GS_HOLDING |-> grip_monitor_en)
    else $error("holding without grip monitoring");
  open_drive_a: assert property (grip_state == GS_RELEASING |-> fingers_open)
    else $error("releasing without opening");
  part_lost_a: assert property (held_loss |=> grip_state == GS_PART_LOST)
    else $error("force loss not reported as part lost");
  no_part_a: assert property (grip_state == GS_GRIPPING && pos_reached && !part_contact && !move_fail
    && clk_en && !cmd_valid && !crit_fault |=> grip_state == GS_NO_PART)
    else $error("closed to position without no-part state");
  stop_idle_a: assert property (taken && cmd_code == CMD_STOP && grip_state != GS_ERROR
    && !crit_fault && !move_fail |=> grip_state == GS_IDLE)
    else $error("stop did not return to idle");
  crit_halt_a: assert property (crit_fault && clk_en && grip_state != GS_IDLE
    |-> ##[1:2] status_word[0] && grip_state == GS_ERROR)
    else $error("critical fault did not halt");
  boot_gap_a: assert property ($rose(boot_restart) |-> red_cnt_q + 2 >= FAIL_CYC
    && red_cnt_q <= FAIL_CYC + 2)
    else $error("load failure red time wrong");
  card_on_a: assert property (card_quiet |-> card_led)
    else $error("card led dark while active and quiet");
endmodule : gsi_core_monitor

bind gsi_core gsi_core_monitor #(.FAIL_CYC(FAIL_CYC)) mon_u (.*);

// >>> tb/gsi_host.sv
// model: host controller issuing gripper commands
`timescale 1ns/1ns
module gsi_host
(
  input wire logic core_clk,
  input wire logic cmd_done,
  input wire logic cmd_ok,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one request, answer taken
  task automatic issue(input logic [7:0] code, output logic ok);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    // inverse code on release, so a stale value never matches
    cmd_code <= ~code;
    @(negedge core_clk);
    ok = (cmd_done === 1'b1) ? cmd_ok : 1'bx;
  endtask : issue
endmodule : gsi_host

// >>> tb/testbench.sv
// testbench: directed scenarios for the gripper state indicator core
`timescale 1ns/1ns
module testbench
  import gsi_pkg::*;
;
  localparam int unsigned T_FAIL = 20;
  localparam int unsigned T_RST = 20, T_CD = 2;
  localparam int BD = 0, BF = 1, TP = 2, SD = 3, SWF = 4, CF = 5, WL = 6, SR = 7, IB = 8;
  localparam int PC = 9, FLS = 10, PR = 11, MF = 12, CA = 13, CT = 14, NA = 15, NT = 16;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [16:0] ev = '0;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic cmd_done;
  logic cmd_ok;
  logic [15:0] status_word;
  logic [2:0] grip_state;
  logic [2:0] led_rgb;
  logic fingers_close;
  logic fingers_open;
  logic part_detect_en;
  logic grip_monitor_en;
  logic boot_restart;
  logic sys_restart;
  logic card_led;
  logic net_led;
  logic dummy;
  int error_cnt = 0;
  int tests_run = 0;
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  gsi_core #(.FAIL_CYC(T_FAIL), .RST_CYC(T_RST), .PULSE_ONCE_CYC(4), .SLOW_CYC(8), .FAST_CYC(4),
    .FL_CYC(2), .CD_CYC(T_CD), .BLINK_CYC(3)) dut_u (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .status_word(status_word),
    .grip_state(grip_state), .boot_done(ev[BD]), .boot_fail(ev[BF]), .terminal_present(ev[TP]),
    .start_done(ev[SD]), .sw_fault(ev[SWF]), .crit_fault(ev[CF]), .warn_limit(ev[WL]),
    .script_run(ev[SR]), .init_busy(ev[IB]), .part_contact(ev[PC]), .force_lost(ev[FLS]),
    .pos_reached(ev[PR]), .move_fail(ev[MF]), .fingers_close(fingers_close),
    .fingers_open(fingers_open), .part_detect_en(part_detect_en),
    .grip_monitor_en(grip_monitor_en), .boot_restart(boot_restart), .sys_restart(sys_restart),
    .led_rgb(led_rgb), .card_active(ev[CA]), .card_traffic(ev[CT]), .net_active(ev[NA]),
    .net_traffic(ev[NT]), .card_led(card_led), .net_led(net_led));
  gsi_host host_u (.core_clk(core_clk), .cmd_done(cmd_done), .cmd_ok(cmd_ok),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic set(input int b, input logic v);
    @(posedge core_clk);
    ev[b] <= v;
    @(negedge core_clk);
  endtask : set
  task automatic pulse(input int b);
    set(b, 1'b1);
    set(b, 1'b0);
  endtask : pulse
  task automatic cmd(input logic [7:0] code, input logic exp_ok);
    logic ok;
    host_u.issue(code, ok);
    chk("cmd_ok", {2'h0, exp_ok}, {2'h0, ok});
  endtask : cmd
  // counts lit, dark and foreign colours; settles two cycles first
  task automatic watch(input logic [2:0] col, input int n, input logic blk);
    int on;
    int off;
    int bad;
    on = 0;
    off = 0;
    bad = 0;
    repeat (2) @(negedge core_clk);
    repeat (n)
    begin
      @(negedge core_clk);
      if (led_rgb === col)
        on++;
      else if (led_rgb === COL_OFF)
        off++;
      else
        bad++;
    end
    chk("led lit dark foreign", {1'b1, blk, 1'b0}, {on > 0, off > 0, bad > 0});
  endtask : watch
  task automatic seen(input logic [2:0] col, input int n);
    int k;
    k = 0;
    while (k < n && led_rgb !== col)
    begin
      @(negedge core_clk);
      k++;
    end
    chk("led colour", col, led_rgb);
  endtask : seen
  // waits for a restart pulse and judges the span from the fault
  task automatic gap(input logic sys, input int span, input int n);
    while (n < 80 && (sys ? sys_restart : boot_restart) !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("restart span", 3'h1, {2'h0, n + 4 >= span && n <= span + 4});
  endtask : gap
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    watch(COL_BLUE, 6, 1'b0);
    set(TP, 1'b1);
    watch(COL_VIOLET, 4, 1'b0);
    set(TP, 1'b0);
    pulse(BF);
    watch(COL_RED, 8, 1'b0);
    gap(1'b0, T_FAIL, 10);
    watch(COL_BLUE, 4, 1'b0);
    pulse(BD);
    watch(COL_BLUE, 8, 1'b1);
    pulse(SD);
    watch(COL_WHITE, 20, 1'b1);
    chk("grip_state", GS_IDLE, grip_state);
  endtask : t_boot
  task automatic t_grip();
    cmd(CMD_GRIP, 1'b1);
    seen(COL_GREEN, 3);
    chk("close", 3'h7, {fingers_close, part_detect_en, grip_state == GS_GRIPPING});
    pulse(PC);
    chk("hold", 3'h3, {1'b0, grip_state == GS_HOLDING, grip_monitor_en});
    pulse(FLS);
    chk("grip_state", GS_PART_LOST, grip_state);
    cmd(CMD_GRIP, 1'b1);
    pulse(PR);
    chk("grip_state", GS_NO_PART, grip_state);
    cmd(CMD_RELEASE, 1'b1);
    chk("open", 3'h3, {1'b0, fingers_open, grip_state == GS_RELEASING});
    pulse(PR);
    chk("grip_state", GS_IDLE, grip_state);
    cmd(CMD_PREPOS, 1'b1);
    chk("grip_state", 3'b110, grip_state);
    cmd(CMD_STOP, 1'b1);
    chk("grip_state", GS_IDLE, grip_state);
    cmd(8'h7e, 1'b0);
    seen(COL_RED, 3);
  endtask : t_grip
  task automatic t_fault();
    set(IB, 1'b1);
    watch(COL_WHITE, 10, 1'b1);
    set(SR, 1'b1);
    watch(COL_GREEN, 10, 1'b1);
    set(WL, 1'b1);
    watch(COL_YELLOW, 10, 1'b1);
    chk("status warn script busy", 3'h7, {status_word[1], status_word[2], status_word[4]});
    cmd(CMD_GRIP, 1'b1);
    set(CF, 1'b1);
    watch(COL_RED, 10, 1'b1);
    chk("error halt", 3'h7, {status_word[3], grip_state == GS_ERROR, status_word[0]});
    cmd(CMD_GRIP, 1'b0);
    cmd(CMD_STATE_QUERY, 1'b1);
    host_u.issue(CMD_ACK, dummy);
    host_u.issue(CMD_STOP, dummy);
    chk("halt kept", 3'h3, {1'b0, grip_state == GS_ERROR, status_word[0]});
    set(CF, 1'b0);
    set(WL, 1'b0);
    set(SR, 1'b0);
    set(IB, 1'b0);
    host_u.issue(CMD_ACK, dummy);
    @(negedge core_clk);
    chk("halt cleared", 3'h0, {2'h0, status_word[0]});
    cmd(CMD_GRIP, 1'b1);
    pulse(MF);
    @(negedge core_clk);
    chk("error halt", 3'h3, {1'b0, grip_state == GS_ERROR, status_word[0]});
    cmd(CMD_GRIP, 1'b0);
  endtask : t_fault
  task automatic t_act();
    logic [1:0] lo;
    lo = 2'b00;
    set(CA, 1'b1);
    set(NA, 1'b1);
    repeat (6) @(negedge core_clk);
    chk("act leds", 3'h3, {1'b0, card_led, net_led});
    set(CT, 1'b1);
    set(NT, 1'b1);
    set(CT, 1'b0);
    set(NT, 1'b0);
    repeat (8)
    begin
      @(negedge core_clk);
      lo = lo | {~card_led, ~net_led};
    end
    chk("act blink", 3'h3, {1'b0, lo});
    chk("act leds", 3'h3, {1'b0, card_led, net_led});
  endtask : t_act
  task automatic t_swf();
    pulse(SWF);
    watch(COL_RED, 12, 1'b1);
    gap(1'b1, T_RST, 14);
    watch(COL_BLUE, 4, 1'b0);
  endtask : t_swf
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(negedge core_clk);
    t_boot();
    $display("test boot done");
    t_grip();
    $display("test grip done");
    t_fault();
    $display("test fault done");
    t_act();
    $display("test activity done");
    t_swf();
    $display("test software fault done");
    print_verdict();
  end
  // scenarios need under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
endmodule : testbench
